// ### include/mrp_regs.svh
/*
 * Register offsets, field positions, reset values and counts of the
 * MII/RMII receive port. Assumes inclusion by bare name from src/.
 */
`ifndef MRP_REGS_SVH
`define MRP_REGS_SVH

// ************************************************************
// Register byte addresses
// ************************************************************
`define MRP_CTRL_ADDR      12'h000
`define MRP_STATUS_ADDR    12'h004
`define MRP_RXDATA_ADDR    12'h008
`define MRP_ERRCNT_ADDR    12'h00c

// ************************************************************
// Fields and reset values
// ************************************************************
`define MRP_CTRL_ENABLE    0
`define MRP_CTRL_SPEED100  1
`define MRP_CTRL_FDX       2
`define MRP_CTRL_RESET     3'h3
`define MRP_ST_COLL        0
`define MRP_ST_OVFL        1
`define MRP_ST_EMPTY       2
`define MRP_ST_RMII        3
`define MRP_ST_DCE         4

// ************************************************************
// Counts
// ************************************************************
`define MRP_RMII_SLOW_DIV  4'h9
`define MRP_HALF_DIV_100   4'h0
`define MRP_HALF_DIV_10    4'h9
`define MRP_FIFO_DEPTH     8
`define MRP_WORD_W         6

`endif

// ### include/mrp_pkg.sv
/*
 * Types of the MII/RMII receive port.
 * Assumes mrp_regs.svh is compiled alongside.
 */
package mrp_pkg;
    typedef enum logic [1:0] {
        MRP_MII_DTE,
        MRP_MII_DCE,
        MRP_RMII
    } mrp_mode_t;
endpackage

// ### src/mrp_receive_port.sv
/*
 * MII/RMII receive port: pin sampling, DCE clock generation, receive
 * FIFO and APB register slave. Assumes a single 200 MHz system clock
 * much faster than the link clocks, which are sampled as pin inputs.
 */
`timescale 1ns/1ps
`default_nettype none
`include "mrp_regs.svh"

// ************************************************************
// Two-flop synchroniser
// ************************************************************
module mrp_sync #(parameter int W = 1) (
    input  wire logic         clk_in,
    input  wire logic         resetn_in,
    input  wire logic [W-1:0] d_in,
    output var  logic [W-1:0] q_out
);
    logic [W-1:0] meta_reg;
    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            meta_reg <= '0;
            q_out    <= '0;
        end else begin
            meta_reg <= d_in;
            q_out    <= meta_reg;
        end
    end
endmodule // mrp_sync

// ************************************************************
// Receive FIFO
// ************************************************************
module mrp_fifo #(parameter int W = 6, parameter int D = 8) (
    input  wire logic         clk_in,
    input  wire logic         resetn_in,
    input  wire logic         in_valid_in,
    output logic              in_ready_out,
    input  wire logic [W-1:0] in_data_in,
    output logic              out_valid_out,
    input  wire logic         out_ready_in,
    output logic [W-1:0]      out_data_out
);
    localparam int AW = $clog2(D);
    logic [W-1:0] mem [D];
    logic [AW-1:0] wr_reg, rd_reg;
    logic [AW:0]   cnt_reg;
    wire           push = in_valid_in && in_ready_out;
    wire           pop  = out_valid_out && out_ready_in;
    assign in_ready_out  = (cnt_reg != (AW+1)'(D));
    assign out_valid_out = (cnt_reg != '0);
    assign out_data_out  = mem[rd_reg];
    always_ff @(posedge clk_in) begin
        if (push) begin
            mem[wr_reg] <= in_data_in;
        end
    end
    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            wr_reg  <= '0;
            rd_reg  <= '0;
            cnt_reg <= '0;
        end else begin
            if (push) wr_reg <= wr_reg + 1'b1;
            if (pop)  rd_reg <= rd_reg + 1'b1;
            cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule // mrp_fifo

module mrp_receive_port
    import mrp_pkg::*;
(
    // System
    input  wire logic        sys_clk_in,
    input  wire logic        resetn_in,
    // APB slave
    input  wire logic        psel_in,
    input  wire logic        penable_in,
    input  wire logic        pwrite_in,
    input  wire logic [11:0] paddr_in,
    input  wire logic [31:0] pwdata_in,
    output logic [31:0]      prdata_out,
    output logic             pready_out,
    output logic             pslverr_out,
    // Mode straps
    input  wire logic        reduced_interface_select_in,
    input  wire logic        clock_role_select_in,
    // Link pins
    input  wire logic        ref_clk_in,
    input  wire logic        rx_clk_in,
    output var  logic        rx_clk_out,
    output logic             rx_clk_oe_out,
    input  wire logic        tx_clk_in,
    output logic             tx_clk_out,
    output logic             tx_clk_oe_out,
    input  wire logic [3:0]  rxd_in,
    input  wire logic        rx_dv_in,
    input  wire logic        carrier_in,
    input  wire logic        rx_err_in,
    input  wire logic        collision_input_in,
    // Transmit timing to the transmit path
    output logic             tx_tick_out
);
    // ************************************************************
    // Pin synchronisation
    // ************************************************************
    logic [12:0] pins_s;
    mrp_sync #(.W(13)) u_sync (
        .clk_in    (sys_clk_in),
        .resetn_in (resetn_in),
        .d_in      ({ref_clk_in, rx_clk_in, tx_clk_in, rxd_in, rx_dv_in,
                     carrier_in, rx_err_in, collision_input_in,
                     reduced_interface_select_in, clock_role_select_in}),
        .q_out     (pins_s)
    );
    wire       ref_s  = pins_s[12];
    wire       rxc_s  = pins_s[11];
    wire       txc_s  = pins_s[10];
    wire [3:0] rxd_s  = pins_s[9:6];
    wire       dv_s   = pins_s[5];
    wire       crs_s  = pins_s[4];
    wire       err_s  = pins_s[3];
    wire       col_s  = pins_s[2];
    wire       rmii_s = pins_s[1];
    wire       dce_s  = pins_s[0];

    logic       ref_d_reg, rxc_d_reg, txc_d_reg;
    logic [2:0] ctrl_reg, ctrl_next;
    logic [3:0] div_reg, slow_reg;
    logic       coll_reg, ovfl_reg;
    logic [15:0] errcnt_reg;
    mrp_mode_t  mode;

    wire enable  = ctrl_reg[`MRP_CTRL_ENABLE];
    wire speed100 = ctrl_reg[`MRP_CTRL_SPEED100];
    wire fdx     = ctrl_reg[`MRP_CTRL_FDX];
    assign mode = rmii_s ? MRP_RMII :
                  (dce_s ? MRP_MII_DCE : MRP_MII_DTE);

    // ************************************************************
    // Edges and DCE clock generation
    // ************************************************************
    wire ref_rise = ref_s && !ref_d_reg;
    wire rxc_rise = rxc_s && !rxc_d_reg;
    wire txc_rise = txc_s && !txc_d_reg;
    wire [3:0] half_div = speed100 ? `MRP_HALF_DIV_100 : `MRP_HALF_DIV_10;
    wire div_wrap = ref_rise && (div_reg >= half_div);
    wire gen_rise = div_wrap && !rx_clk_out;
    wire is_dce   = (mode == MRP_MII_DCE);

    always_ff @(posedge sys_clk_in) begin
        if (!resetn_in) begin
            ref_d_reg <= 1'b0;
            rxc_d_reg <= 1'b0;
            txc_d_reg <= 1'b0;
        end else begin
            ref_d_reg <= ref_s;
            rxc_d_reg <= rxc_s;
            txc_d_reg <= txc_s;
        end
    end

    // Half-period divider from the reference clock
    always_ff @(posedge sys_clk_in) begin
        if (!resetn_in || !is_dce) begin
            div_reg    <= 4'h0;
            rx_clk_out <= 1'b0;
        end else if (div_wrap) begin
            div_reg    <= 4'h0;
            rx_clk_out <= !rx_clk_out;
        end else if (ref_rise) begin
            div_reg    <= div_reg + 4'h1;
        end
    end
    assign rx_clk_oe_out = is_dce;
    assign tx_clk_out    = rx_clk_out;
    assign tx_clk_oe_out = is_dce;
    assign tx_tick_out   = is_dce ? gen_rise : txc_rise;

    // ************************************************************
    // Receive sampling
    // ************************************************************
    wire slow_hit = (slow_reg == `MRP_RMII_SLOW_DIV);
    wire rmii_evt = ref_rise && (speed100 || slow_hit);
    wire mii_evt  = is_dce ? gen_rise : rxc_rise;
    wire samp_evt = (mode == MRP_RMII) ? rmii_evt : mii_evt;
    wire data_ok  = (mode == MRP_RMII) ? crs_s : dv_s;
    wire err_ok   = err_s && crs_s;
    wire take     = enable && samp_evt && data_ok;
    wire [5:0] word = {err_ok, (mode == MRP_RMII),
                       (mode == MRP_RMII) ? {2'b00, rxd_s[1:0]} : rxd_s};
    wire fifo_in_rdy;
    wire fifo_out_vld;
    wire [5:0] fifo_out;

    always_ff @(posedge sys_clk_in) begin
        if (!resetn_in || mode != MRP_RMII) begin
            slow_reg <= 4'h0;
        end else if (ref_rise) begin
            slow_reg <= slow_hit ? 4'h0 : slow_reg + 4'h1;
        end
    end

    // ************************************************************
    // APB slave
    // ************************************************************
    wire acc      = psel_in && penable_in;
    wire hit_ctrl = (paddr_in == `MRP_CTRL_ADDR);
    wire hit_st   = (paddr_in == `MRP_STATUS_ADDR);
    wire hit_data = (paddr_in == `MRP_RXDATA_ADDR);
    wire hit_err  = (paddr_in == `MRP_ERRCNT_ADDR);
    wire mapped   = hit_ctrl || hit_st || hit_data || hit_err;
    wire wr_ctrl  = acc && pwrite_in && hit_ctrl;
    wire wr_st    = acc && pwrite_in && hit_st;
    wire wr_err   = acc && pwrite_in && hit_err;
    wire pop      = acc && !pwrite_in && hit_data && fifo_out_vld;
    wire coll_evt = enable && !fdx && col_s && !rmii_s;
    wire ovfl_evt = take && !fifo_in_rdy;
    assign pready_out  = 1'b1;
    assign pslverr_out = acc && !mapped;
    assign ctrl_next   = wr_ctrl ? pwdata_in[2:0] : ctrl_reg;

    mrp_fifo #(.W(`MRP_WORD_W), .D(`MRP_FIFO_DEPTH)) u_fifo (
        .clk_in        (sys_clk_in),
        .resetn_in     (resetn_in),
        .in_valid_in   (take),
        .in_ready_out  (fifo_in_rdy),
        .in_data_in    (word),
        .out_valid_out (fifo_out_vld),
        .out_ready_in  (pop),
        .out_data_out  (fifo_out)
    );

    always_comb begin
        prdata_out = 32'h0;
        if (hit_ctrl) prdata_out = {29'h0, ctrl_reg};
        if (hit_st)   prdata_out = {27'h0, dce_s, rmii_s, !fifo_out_vld,
                                    ovfl_reg, coll_reg};
        if (hit_data) prdata_out = {fifo_out_vld, 25'h0, fifo_out};
        if (hit_err)  prdata_out = {16'h0, errcnt_reg};
    end

    // Sticky flags: write one clears, a new event wins over the clear
    always_ff @(posedge sys_clk_in) begin
        if (!resetn_in) begin
            ctrl_reg   <= `MRP_CTRL_RESET;
            coll_reg   <= 1'b0;
            ovfl_reg   <= 1'b0;
            errcnt_reg <= 16'h0;
        end else begin
            ctrl_reg <= ctrl_next;
            coll_reg <= coll_evt ||
                        (coll_reg && !(wr_st && pwdata_in[`MRP_ST_COLL]));
            ovfl_reg <= ovfl_evt ||
                        (ovfl_reg && !(wr_st && pwdata_in[`MRP_ST_OVFL]));
            if (take && err_ok && errcnt_reg != 16'hffff) begin
                errcnt_reg <= errcnt_reg + 16'h1;
            end else if (wr_err) begin
                errcnt_reg <= 16'h0;
            end
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    sequence s_ref_edge;
        ref_rise && mode == MRP_RMII && !speed100;
    endsequence
    chk_fdx_no_coll: assert property (@(posedge sys_clk_in)
        disable iff (!resetn_in) fdx |-> !coll_evt)
        else $error("collision heeded in full duplex");
    chk_coll_sets_flag: assert property (@(posedge sys_clk_in)
        disable iff (!resetn_in) coll_evt |=> coll_reg)
        else $error("collision flag not set");
    chk_dte_no_drive: assert property (@(posedge sys_clk_in)
        disable iff (!resetn_in) !is_dce |-> !rx_clk_oe_out && !rx_clk_out)
        else $error("receive clock driven in DTE");
    chk_mii_dv_gate: assert property (@(posedge sys_clk_in)
        disable iff (!resetn_in)
        (mode != MRP_RMII && !dv_s) |-> !take)
        else $error("nibble taken without valid");
    chk_rmii_crs_gate: assert property (@(posedge sys_clk_in)
        disable iff (!resetn_in)
        (mode == MRP_RMII && !crs_s) |-> !take)
        else $error("dibit taken without sense");
    chk_rmii_slow_rate: assert property (@(posedge sys_clk_in)
        disable iff (!resetn_in)
        (s_ref_edge and rmii_evt) |=> !rmii_evt [*8])
        else $error("slow RMII sampled too often");
    chk_err_gate: assert property (@(posedge sys_clk_in)
        disable iff (!resetn_in)
        (!crs_s && !wr_err) |=> $stable(errcnt_reg))
        else $error("error counted without sense");
    chk_take_push: assert property (@(posedge sys_clk_in)
        disable iff (!resetn_in)
        (take && fifo_in_rdy && !pop) |=> fifo_out_vld)
        else $error("sample not buffered");
    chk_dce_toggle: assert property (@(posedge sys_clk_in)
        disable iff (!resetn_in)
        (is_dce && div_wrap) |=> $changed(rx_clk_out))
        else $error("generated clock did not toggle");
endmodule // mrp_receive_port
`default_nettype wire

// ### test/mrp_phy_model.sv
/* Partner model of the PHY side of the receive port.
   Assumes the bench sets the mode and calls send, idle and collide. */
`timescale 1ns/1ps
`default_nettype none
module mrp_phy_model (
    // Mode
    input  wire logic       rmii_in,
    input  wire logic       dce_in,
    input  wire logic       gen_clk_in,
    // Pins
    output logic            ref_clk_out,
    output logic            rx_clk_out,
    output logic            tx_clk_out,
    output logic [3:0]      rxd_out,
    output logic            rx_dv_out,
    output logic            carrier_out,
    output logic            rx_err_out,
    output logic            collision_out
);
    wire lclk = rmii_in ? ref_clk_out : (dce_in ? gen_clk_in : rx_clk_out);

    initial begin
        ref_clk_out = 1'b0;
        forever #20 ref_clk_out = ~ref_clk_out;
    end
    initial begin
        rx_clk_out = 1'b0;
        // Half the reference rate, as the generated clock runs at 100M
        forever #40 rx_clk_out = ~rx_clk_out;
    end
    assign tx_clk_out = ~rx_clk_out;
    initial begin
        rxd_out = 4'h0;
        rx_dv_out = 1'b0;
        carrier_out = 1'b0;
        rx_err_out = 1'b0;
        collision_out = 1'b0;
    end

    // Lines move on the falling edge, stable at the sampling rise
    task automatic send(input logic [3:0] d, input logic dv,
                        input logic crs, input logic err, input int n);
        @(negedge lclk);
        rxd_out = (dv | crs) ? d : ~rxd_out;
        rx_dv_out = dv;
        carrier_out = crs;
        rx_err_out = err;
        repeat (n) @(posedge lclk);
    endtask
    task automatic idle(input int n);
        @(negedge lclk);
        rxd_out = ~rxd_out;
        rx_dv_out = 1'b0;
        carrier_out = dce_in & ~rmii_in;
        rx_err_out = 1'b0;
        repeat (n) @(posedge lclk);
    endtask
    task automatic collide(input int n);
        @(negedge lclk);
        collision_out = ~dce_in;
        repeat (n) @(posedge lclk);
        collision_out = 1'b0;
    endtask
endmodule // mrp_phy_model
`default_nettype wire

// ### test/tb_top.sv
/* Self-checking bench of the receive port: APB master, PHY model,
   random units in every mode. Assumes the design and its header. */
`timescale 1ns/1ps
`default_nettype none
`include "mrp_regs.svh"
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin \
    miscompares++; $display("unexpected %s exp %h got %h", nm, e, g); end end
module tb_top;
    logic        clk, rstn, psel, pen, pwr, rm, dce;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rword, rv, seed = 32'h42;
    logic        pready, perr, pslverr, refc, rxc, txc, rxco, rxoe;
    logic        txco, txoe, tick, dv, crs, err, col;
    logic [3:0]  rxd;
    logic [15:0] nerr;
    logic [31:0] q[$];
    int          miscompares = 0, n_compared = 0, n_rise = 0, n_tick = 0;
    wire rx_pin = rxoe ? rxco : rxc;
    wire tx_pin = txoe ? txco : txc;

    mrp_receive_port dut (.sys_clk_in(clk), .resetn_in(rstn),
        .psel_in(psel), .penable_in(pen), .pwrite_in(pwr),
        .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
        .pready_out(pready), .pslverr_out(pslverr),
        .reduced_interface_select_in(rm), .clock_role_select_in(dce),
        .ref_clk_in(refc), .rx_clk_in(rx_pin), .rx_clk_out(rxco),
        .rx_clk_oe_out(rxoe), .tx_clk_in(tx_pin), .tx_clk_out(txco),
        .tx_clk_oe_out(txoe), .rxd_in(rxd), .rx_dv_in(dv),
        .carrier_in(crs), .rx_err_in(err), .collision_input_in(col),
        .tx_tick_out(tick));
    mrp_phy_model phy (.rmii_in(rm), .dce_in(dce), .gen_clk_in(rx_pin),
        .ref_clk_out(refc), .rx_clk_out(rxc), .tx_clk_out(txc),
        .rxd_out(rxd), .rx_dv_out(dv), .carrier_out(crs),
        .rx_err_out(err), .collision_out(col));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    always @(posedge tx_pin) n_rise++;
    always @(posedge clk) if (tick === 1'b1) n_tick++;

    // ******************************
    // Helpers
    // ******************************
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [31:0] exp_word(logic [3:0] d, logic e);
        return {1'b1, 25'h0, e, rm, rm ? {2'b00, d[1:0]} : d};
    endfunction
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rword = prdata;
        perr = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask
    task automatic reset(input logic r, input logic c);
        @(posedge clk);
        rstn <= 1'b0;
        rm <= r;
        dce <= c;
        nerr = 16'h0;
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        phy.idle(1);
        apb(1'b0, `MRP_STATUS_ADDR, 32'h0);
        `CHK("status", {c, r, 3'h4}, rword[4:0])
        `CHK("clk oe", c & ~r, rxoe & txoe)
    endtask
    // Random units with refused gaps between them
    task automatic frame(input int n, input int hold);
        logic [31:0] r;
        logic        e, c;
        for (int i = 0; i < n; i++) begin
            r = rnd();
            if (r[9:8] == 2'b00) phy.send(~r[3:0], 1'b0, dce, ~dce, hold);
            c = rm | dce | (r[7:6] != 2'b00);
            e = r[4] & ~dce & (i < 8);
            phy.send(r[3:0], 1'b1, c, e, hold);
            if (i < 8) q.push_back(exp_word(r[3:0], e & c));
            if (e & c) nerr++;
        end
        phy.idle(2);
    endtask
    task automatic drain();
        logic [31:0] x;
        while (q.size() > 0) begin
            x = q.pop_front();
            apb(1'b0, `MRP_RXDATA_ADDR, 32'h0);
            `CHK("rxdata", x, rword)
        end
        apb(1'b0, `MRP_RXDATA_ADDR, 32'h0);
        `CHK("empty pop", 1'b0, rword[31])
        apb(1'b0, `MRP_ERRCNT_ADDR, 32'h0);
        `CHK("errcnt", nerr, rword[15:0])
    endtask
    task automatic clk_count(input int ex);
        int r0, t0;
        r0 = n_rise;
        t0 = n_tick;
        repeat (40) @(posedge refc);
        r0 = n_rise - r0;
        t0 = n_tick - t0;
        `CHK("rises", 1'b1, (r0 >= ex - 1) && (r0 <= ex + 1))
        `CHK("ticks", 1'b1, (t0 >= r0 - 1) && (t0 <= r0 + 1))
    endtask
    task automatic stop_test();
        $display("compared %0d mismatched %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    // ******************************
    // Scenarios
    // ******************************
    initial begin
        rstn = 1'b0;
        {psel, pen, pwr, rm, dce} = 5'h0;
        paddr = 12'h0;
        pwdata = 32'h0;
        reset(1'b0, 1'b0);
        apb(1'b0, `MRP_CTRL_ADDR, 32'h0);
        `CHK("ctrl", 32'h3, rword)
        apb(1'b0, 12'h010, 32'h0);
        `CHK("slverr", 1'b1, perr)
        // Random write to an unmapped word, then random upper ctrl bits
        rv = rnd();
        apb(1'b1, {rv[11:5], 1'b1, rv[3:2], 2'b00}, rv);
        `CHK("slverr wr", 1'b1, perr)
        apb(1'b1, `MRP_CTRL_ADDR, {rv[31:3], 3'h3});
        apb(1'b0, `MRP_CTRL_ADDR, 32'h0);
        `CHK("ctrl keep", 32'h3, rword)
        frame(8, 1);
        drain();
        frame(9, 1);
        apb(1'b0, `MRP_STATUS_ADDR, 32'h0);
        `CHK("ovfl", 1'b1, rword[1])
        apb(1'b1, `MRP_STATUS_ADDR, 32'h2);
        drain();
        phy.collide(2);
        phy.idle(1);
        apb(1'b0, `MRP_STATUS_ADDR, 32'h0);
        `CHK("coll half", 2'h0, rword[1:0] ^ 2'h1)
        apb(1'b1, `MRP_STATUS_ADDR, 32'h1);
        apb(1'b1, `MRP_CTRL_ADDR, 32'h7);
        phy.collide(2);
        phy.idle(1);
        apb(1'b0, `MRP_STATUS_ADDR, 32'h0);
        `CHK("coll full", 1'b0, rword[0])
        clk_count(20);
        reset(1'b1, 1'b0);
        frame(8, 1);
        drain();
        apb(1'b1, `MRP_CTRL_ADDR, 32'h1);
        frame(6, 10);
        drain();
        reset(1'b0, 1'b1);
        `CHK("tx clk", rxco, txco)
        clk_count(20);
        frame(6, 1);
        drain();
        apb(1'b1, `MRP_CTRL_ADDR, 32'h1);
        clk_count(2);
        frame(3, 1);
        drain();
        stop_test();
    end
    initial begin
        #300_000;
        miscompares++;
        stop_test();
    end
endmodule // tb_top
`default_nettype wire
